// ===== host_port_fifo_burst_pkg.sv
`default_nettype none
package host_port_fifo_burst_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int          DEPTH      = 8;
    localparam int          WIDTH      = 32;
    localparam int          PTR_W      = 3;
    localparam int          CNT_W      = 4;
    localparam int          LEN_W      = 3;
    localparam int          TMO_W      = 16;
    localparam logic [3:0]  FULL_CNT   = 4'h8;
    localparam logic [3:0]  BURST_CNT  = 4'h4;
    localparam logic [2:0]  BURST_LEN  = 3'h4;
    localparam logic [2:0]  SINGLE_LEN = 3'h1;
    localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;

    ////////////////////////////////////////////////////////////////////////////////
    // Register word addresses
    localparam logic [2:0] CTRL_OFS    = 3'h0;
    localparam logic [2:0] CONFIG_OFS  = 3'h1;
    localparam logic [2:0] RD_ADDR_OFS = 3'h2;
    localparam logic [2:0] WR_ADDR_OFS = 3'h3;
    localparam logic [2:0] SH_ADDR_OFS = 3'h4;
    localparam logic [2:0] DATA_AI_OFS = 3'h5;
    localparam logic [2:0] DATA_SG_OFS = 3'h6;
    localparam logic [2:0] STATUS_OFS  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int              SPLIT_BIT = 0;
    localparam int              FETCH_BIT = 1;
    localparam logic [TMO_W-1:0] TMO_RESET = 16'h0100;

    typedef enum logic [1:0] {DMA_IDLE, DMA_READ, DMA_WRITE} dma_state_t;

    typedef struct packed {
        logic             req;
        logic             we;
        logic [31:0]      addr;
        logic [LEN_W-1:0] len;
        logic [31:0]      wdata;
    } dma_cmd_t;

    typedef struct packed {
        logic                        wait_r;
        logic [31:0]                 rdata;
        logic                        hrn;
        logic                        arm;
        logic                        split;
        logic [TMO_W-1:0]            tmo;
        logic [TMO_W-1:0]            tcnt;
        logic [31:0]                 rd_addr;
        logic [31:0]                 wr_addr;
        logic [DEPTH-1:0][WIDTH-1:0] rfifo;
        logic [PTR_W-1:0]            rwp;
        logic [PTR_W-1:0]            rrp;
        logic [CNT_W-1:0]            rcnt;
        logic [DEPTH-1:0][WIDTH-1:0] wfifo;
        logic [PTR_W-1:0]            wwp;
        logic [PTR_W-1:0]            wrp;
        logic [CNT_W-1:0]            wcnt;
        logic                        prefetch;
        logic                        single_req;
        logic                        rflush;
        logic                        wflush;
        dma_state_t                  dma_st;
        logic [LEN_W-1:0]            remain;
        dma_cmd_t                    cmd;
    } state_t;

endpackage
`default_nettype wire

// ===== host_port_fifo_burst.sv
// Summary of operation
// R1: Writing the read address register flushes the read FIFO, discarding its data.
// R2: A DMA write into the read FIFO finishes before the read flush.
// R3: Read bursting starts on autoincrement data read or prefetch command.
// R4: Autoincrement read fills FIFO with two 4-word bursts; host held until data.
// R5: Afterwards a 4-word burst whenever four locations free, until read flush.
// R6: Prefetch command bit stores nothing; writing 1 starts prefetching.
// R7: Host precedes a prefetch command with an address write or single access.
// R8: Single data read flushes read FIFO, fetches one word, stops prefetching.
// R9: Writing the write address register drains the write FIFO to memory.
// R10: Autoincrement writes queue; 4-word bursts while at least four words held.
// R11: With eight words in the write FIFO the host is held off.
// R12: On timeout fewer than four words drain as one short burst or single.
// R13: Timeout counter restarts on every push; period from write_timeout_field.
// R14: Software changes write_timeout_field once, with FIFOs empty and idle.
// R15: Single data write flushes write FIFO, writes one word, stops bursting.
// R16: Host precedes a single data write with an address write or single access.
// R17: Read flush waits for ongoing host access and DMA, then resets pointers.
// R18: Write flush waits for pending work, then forces posted writes out.
// R19: Data cycles arriving during a flush are held off until it completes.
// R20: Split mode off: any flush or shared address write flushes both FIFOs.
// R21: Split mode off: autoinc access against the other nonempty FIFO flushes both.
// R22: Split mode on: address registers independent, flushes do not couple.
// R23: Read and write FIFOs are eight 32-bit words deep.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module host_port_fifo_burst
    import host_port_fifo_burst_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        host_ready_n,
    output var  dma_cmd_t    dma_cmd,
    input  wire logic        dma_gnt,
    input  wire logic        dma_rvalid,
    input  wire logic [31:0] dma_rdata,
    input  wire logic        dma_wack
);

    state_t s;
    state_t next_s;

    logic   req;
    logic   is_data;
    logic   ok;
    logic   set_rf;
    logic   set_wf;
    logic   rpush;
    logic   rpop;
    logic   wpush;
    logic   wpop;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_s     = s;
        next_s.wait_r = 1'b1;
        req        = (avs_read | avs_write) & s.wait_r;
        is_data    = (avs_address == DATA_AI_OFS) | (avs_address == DATA_SG_OFS);
        ok         = 1'b0;
        set_rf     = 1'b0;
        set_wf     = 1'b0;
        rpush      = 1'b0;
        rpop       = 1'b0;
        wpush      = 1'b0;
        wpop       = 1'b0;

        // First cycle of a request raises its flush conditions
        if (req && !s.arm)
        begin
            next_s.arm = 1'b1;
            case (avs_address)
                RD_ADDR_OFS:
                begin
                    // R1: read address write flushes
                    set_rf = avs_write;
                end
                WR_ADDR_OFS:
                begin
                    // R9: write address write flushes
                    set_wf = avs_write;
                end
                SH_ADDR_OFS:
                begin
                    // R20: shared address flushes both
                    set_rf = avs_write;
                    set_wf = avs_write;
                end
                DATA_AI_OFS:
                begin
                    // R21: direction change flushes both
                    set_rf = !s.split && (avs_read ? s.wcnt != '0 : s.rcnt != '0);
                end
                DATA_SG_OFS:
                begin
                    // R8: single read flushes, fetches one
                    if (avs_read)
                    begin
                        set_rf            = 1'b1;
                        next_s.single_req = 1'b1;
                    end
                    // R15: single write flushes first
                    set_wf = avs_write;
                end
                default:
                begin
                end
            endcase
        end

        // Armed request waits for its resource
        if (req && s.arm)
        begin
            case (avs_address)
                RD_ADDR_OFS:
                begin
                    // R17: address changes after flush completes
                    ok = avs_read | (!s.rflush && s.dma_st != DMA_READ);
                end
                WR_ADDR_OFS:
                    ok = avs_read | (!s.wflush && s.dma_st != DMA_WRITE);
                SH_ADDR_OFS:
                    ok = avs_read | (!s.rflush && !s.wflush && s.dma_st == DMA_IDLE);
                DATA_AI_OFS:
                begin
                    if (avs_read)
                    begin
                        // R4: held until read data available
                        ok = !s.rflush && s.rcnt != '0 &&
                             (s.split || (s.wcnt == '0 && !s.wflush));
                        // R3: autoincrement read starts prefetch
                        if (!s.rflush)
                            next_s.prefetch = 1'b1;
                    end
                    else
                    begin
                        // R11: full write FIFO holds host off
                        ok = !s.wflush && s.wcnt != FULL_CNT &&
                             (s.split || (s.rcnt == '0 && !s.rflush));
                    end
                end
                DATA_SG_OFS:
                begin
                    // R19: held off while flushing
                    if (avs_read)
                        ok = !s.rflush && !s.single_req && s.rcnt != '0;
                    else
                        ok = !s.wflush && s.wcnt == '0 && s.dma_st == DMA_IDLE;
                end
                default:
                    ok = 1'b1;
            endcase
        end

        next_s.hrn = req && is_data && !ok;

        ////////////////////////////////////////////////////////////////////////////////
        // Accepted access
        if (ok)
        begin
            next_s.wait_r = 1'b0;
            next_s.arm    = 1'b0;
            next_s.rdata  = '0;
            case (avs_address)
                CTRL_OFS:
                begin
                    next_s.rdata[SPLIT_BIT] = s.split;
                    if (avs_write)
                        next_s.split = avs_writedata[SPLIT_BIT];
                end
                CONFIG_OFS:
                begin
                    next_s.rdata[TMO_W-1:0] = s.tmo;
                    if (avs_write)
                        next_s.tmo = avs_writedata[TMO_W-1:0];
                end
                RD_ADDR_OFS, SH_ADDR_OFS:
                begin
                    next_s.rdata = s.rd_addr;
                    if (avs_write)
                    begin
                        next_s.rd_addr = avs_writedata;
                        // R22: shared write sets both pointers
                        if (avs_address == SH_ADDR_OFS)
                            next_s.wr_addr = avs_writedata;
                    end
                end
                WR_ADDR_OFS:
                begin
                    next_s.rdata = s.wr_addr;
                    if (avs_write)
                        next_s.wr_addr = avs_writedata;
                end
                DATA_AI_OFS, DATA_SG_OFS:
                begin
                    if (avs_read)
                    begin
                        next_s.rdata = s.rfifo[s.rrp];
                        rpop         = 1'b1;
                        next_s.rrp   = PTR_W'(s.rrp + 1'b1);
                    end
                    else
                    begin
                        // R10: autoincrement writes queue
                        wpush                  = 1'b1;
                        next_s.wfifo[s.wwp]    = avs_writedata;
                        next_s.wwp             = PTR_W'(s.wwp + 1'b1);
                        // R15: lone word written singly
                        if (avs_address == DATA_SG_OFS)
                            next_s.wflush = 1'b1;
                    end
                end
                default:
                begin
                    next_s.rdata = {20'h00000, s.rcnt, s.wcnt, s.prefetch,
                                    s.single_req, s.rflush, s.wflush};
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Write timeout
        // R13: restart on new data
        if (wpush)
            next_s.tcnt = '0;
        else if (s.wcnt != '0 && s.wcnt < BURST_CNT && !s.wflush && s.dma_st == DMA_IDLE)
        begin
            // R12: expiry drains short remainder
            if (s.tcnt >= s.tmo)
            begin
                set_wf      = 1'b1;
                next_s.tcnt = '0;
            end
            else
                next_s.tcnt = TMO_W'(s.tcnt + 1'b1);
        end

        ////////////////////////////////////////////////////////////////////////////////
        // DMA engine
        if (s.cmd.req && dma_gnt)
            next_s.cmd.req = 1'b0;
        case (s.dma_st)
            DMA_IDLE:
            begin
                if (s.rflush)
                begin
                    // R17: pointers reset once DMA idle
                    next_s.rrp      = '0;
                    next_s.rwp      = '0;
                    next_s.prefetch = 1'b0;
                    next_s.rflush   = 1'b0;
                end
                else if (s.wcnt >= BURST_CNT || (s.wflush && s.wcnt != '0))
                begin
                    // R18: posted words forced out
                    next_s.cmd.req   = 1'b1;
                    next_s.cmd.we    = 1'b1;
                    next_s.cmd.addr  = s.wr_addr;
                    next_s.cmd.len   = (s.wcnt >= BURST_CNT) ? BURST_LEN : s.wcnt[LEN_W-1:0];
                    next_s.cmd.wdata = s.wfifo[s.wrp];
                    next_s.remain    = next_s.cmd.len;
                    next_s.dma_st    = DMA_WRITE;
                end
                else if (s.wflush)
                    next_s.wflush = 1'b0;
                else if (s.single_req)
                begin
                    next_s.cmd.req    = 1'b1;
                    next_s.cmd.we     = 1'b0;
                    next_s.cmd.addr   = s.rd_addr;
                    next_s.cmd.len    = SINGLE_LEN;
                    next_s.remain     = SINGLE_LEN;
                    next_s.single_req = 1'b0;
                    next_s.dma_st     = DMA_READ;
                end
                // R5: burst whenever four locations free
                else if (s.prefetch && (FULL_CNT - s.rcnt) >= BURST_CNT)
                begin
                    next_s.cmd.req  = 1'b1;
                    next_s.cmd.we   = 1'b0;
                    next_s.cmd.addr = s.rd_addr;
                    next_s.cmd.len  = BURST_LEN;
                    next_s.remain   = BURST_LEN;
                    next_s.dma_st   = DMA_READ;
                end
            end
            DMA_READ:
            begin
                if (dma_rvalid)
                begin
                    // R2: incoming words land before flush
                    rpush               = 1'b1;
                    next_s.rfifo[s.rwp] = dma_rdata;
                    next_s.rwp          = PTR_W'(s.rwp + 1'b1);
                    next_s.rd_addr      = s.rd_addr + ADDR_STEP;
                    next_s.remain       = LEN_W'(s.remain - 1'b1);
                    if (s.remain == SINGLE_LEN)
                        next_s.dma_st = DMA_IDLE;
                end
            end
            DMA_WRITE:
            begin
                if (dma_wack)
                begin
                    wpop             = 1'b1;
                    next_s.wrp       = PTR_W'(s.wrp + 1'b1);
                    next_s.cmd.wdata = s.wfifo[PTR_W'(s.wrp + 1'b1)];
                    next_s.wr_addr   = s.wr_addr + ADDR_STEP;
                    next_s.remain    = LEN_W'(s.remain - 1'b1);
                    if (s.remain == SINGLE_LEN)
                        next_s.dma_st = DMA_IDLE;
                end
            end
            default:
                next_s.dma_st = DMA_IDLE;
        endcase

        // R23: occupancy of the eight-word FIFOs
        next_s.rcnt = CNT_W'(s.rcnt + CNT_W'(rpush) - CNT_W'(rpop));
        next_s.wcnt = CNT_W'(s.wcnt + CNT_W'(wpush) - CNT_W'(wpop));
        if (s.dma_st == DMA_IDLE && s.rflush)
            next_s.rcnt = '0;

        // R20: coupled flushes when split mode off
        if (!s.split && (set_rf || set_wf))
        begin
            set_rf = 1'b1;
            set_wf = 1'b1;
        end
        if (set_rf)
            next_s.rflush = 1'b1;
        if (set_wf)
            next_s.wflush = 1'b1;

        // R6: prefetch command is decoded, not stored
        if (ok && avs_write && avs_address == CTRL_OFS && avs_writedata[FETCH_BIT])
            next_s.prefetch = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s        <= '0;
            s.wait_r <= 1'b1;
            s.tmo    <= TMO_RESET;
        end
        else
            s <= next_s;
    end

    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.wait_r;
    assign host_ready_n    = s.hrn;
    assign dma_cmd         = s.cmd;

endmodule // host_port_fifo_burst
`default_nettype wire

// ===== host_port_fifo_burst_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_fifo_burst_assertions
    import host_port_fifo_burst_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        host_ready_n,
    input wire dma_cmd_t    dma_cmd,
    input wire logic        dma_gnt,
    input wire logic        dma_rvalid,
    input wire logic [31:0] dma_rdata,
    input wire logic        dma_wack
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic data_acc;
    assign data_acc = (avs_address == DATA_AI_OFS) || (avs_address == DATA_SG_OFS);

    ////////////////////////////////////////////////////////////////////////////////
    // Host side
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("access accepted without a request");
    hold_cause_a: assert property (host_ready_n |->
        $past(avs_read || avs_write) && $past(data_acc))
        else $error("hold-off without a pending data access");
    idle_ready_a: assert property (!(avs_read || avs_write) |=> !host_ready_n)
        else $error("hold-off while host idle");
    reg_ready_a: assert property ((avs_read || avs_write) && !data_acc |=> !host_ready_n)
        else $error("hold-off on a register access");
    rdata_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data changed outside an accept");

    ////////////////////////////////////////////////////////////////////////////////
    // Memory side
    read_len_a: assert property (dma_cmd.req && !dma_cmd.we |->
        dma_cmd.len == BURST_LEN || dma_cmd.len == SINGLE_LEN)
        else $error("read command of illegal length");
    write_len_a: assert property (dma_cmd.req && dma_cmd.we |->
        dma_cmd.len >= SINGLE_LEN && dma_cmd.len <= BURST_LEN)
        else $error("write command of illegal length");
    cmd_hold_a: assert property (dma_cmd.req && !dma_gnt |=>
        dma_cmd.req && $stable(dma_cmd))
        else $error("command changed before grant");

    fill_cov: cover property (dma_cmd.req && !dma_cmd.we && dma_cmd.len == BURST_LEN);
    short_cov: cover property (dma_cmd.req && dma_cmd.we && dma_cmd.len < BURST_LEN);
    hold_cov: cover property ($rose(host_ready_n));
endmodule // host_port_fifo_burst_assertions

bind host_port_fifo_burst host_port_fifo_burst_assertions i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_ready_n(host_ready_n), .dma_cmd(dma_cmd),
    .dma_gnt(dma_gnt), .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .dma_wack(dma_wack)
);
`default_nettype wire

// ===== mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import host_port_fifo_burst_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        stall,
    input  wire dma_cmd_t    dma_cmd,
    output var  logic        dma_gnt,
    output var  logic        dma_rvalid,
    output var  logic [31:0] dma_rdata,
    output var  logic        dma_wack
);
    logic [31:0] mem [0:255];
    logic [31:0] addr;
    logic [2:0]  left;
    logic        busy;
    logic        we;
    integer      seed = 32'h6dd57ebd;
    integer      rnd;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = {22'h0, i[7:0], 2'b00} ^ 32'h5a5a_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Grant, then exactly len word pulses, random latency
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            left <= 3'h0;
            dma_gnt <= 1'b0;
            dma_rvalid <= 1'b0;
            dma_wack <= 1'b0;
            dma_rdata <= 32'h0;
        end
        else
        begin
            rnd = $random(seed);
            dma_rvalid <= 1'b0;
            dma_wack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_wack)
            begin
                mem[addr[9:2]] <= dma_cmd.wdata;
                addr <= addr + ADDR_STEP;
            end
            if (dma_gnt)
            begin
                dma_gnt <= 1'b0;
                busy <= 1'b1;
                addr <= dma_cmd.addr;
                left <= dma_cmd.len;
                we <= dma_cmd.we;
            end
            else if (!busy && dma_cmd.req && !stall && rnd[0])
                dma_gnt <= 1'b1;
            else if (busy && left != 3'h0 && rnd[1])
            begin
                left <= left - 3'h1;
                dma_wack <= we;
                dma_rvalid <= !we;
                if (!we)
                begin
                    dma_rdata <= mem[addr[9:2]];
                    addr <= addr + ADDR_STEP;
                end
            end
            else if (busy && left == 3'h0 && !dma_wack && !dma_rvalid)
                busy <= 1'b0;
        end
    end
endmodule // mem_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
    import host_port_fifo_burst_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        host_ready_n;
    dma_cmd_t    dma_cmd;
    logic        dma_gnt;
    logic        dma_rvalid;
    logic        dma_wack;
    logic [31:0] dma_rdata;
    logic        stall = 1'b0;
    integer      seed = 32'h6dd57ebd;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [31:0] rd;
    logic [31:0] base;
    logic [31:0] wd [0:9];

    always #50 ref_clk = ~ref_clk;

    host_port_fifo_burst i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .host_ready_n(host_ready_n), .dma_cmd(dma_cmd),
        .dma_gnt(dma_gnt), .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .dma_wack(dma_wack));
    mem_model i_mem (
        .ref_clk(ref_clk), .rstn(rstn), .stall(stall), .dma_cmd(dma_cmd), .dma_gnt(dma_gnt),
        .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .dma_wack(dma_wack));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {22'h0, a[9:2], 2'b00} ^ 32'h5a5a_0000;
    endfunction

    task automatic bus(input logic we, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !we;
        avs_write <= we;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 4000)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 4000)
            fail_count++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_seq(input logic [31:0] a, input int n);
        for (int i = 0; i < n; i++)
        begin
            bus(1'b0, DATA_AI_OFS, 32'h0);
            `CHK(rd, word_at(a + 4 * i))
        end
    endtask

    task automatic wr_seq(input int n);
        for (int i = 0; i < n; i++)
        begin
            wd[i] = $random(seed);
            bus(1'b1, DATA_AI_OFS, wd[i]);
        end
    endtask

    task automatic mem_chk(input logic [31:0] a, input int n);
        for (int i = 0; i < n; i++)
            `CHK(i_mem.mem[a[9:2] + i], wd[i])
    endtask

    task automatic done(input string s);
        $display("test %s over", s);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        `CHK(avs_waitrequest, 1'b1)
        `CHK(host_ready_n, 1'b0)
        `CHK(dma_cmd.req, 1'b0)
        rstn <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, CONFIG_OFS, 32'h0);
        `CHK(rd, {16'h0, TMO_RESET})
        bus(1'b1, CONFIG_OFS, 32'h0000_0020);
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        done("setup");
        for (int k = 0; k < 3; k++)
        begin
            base = ($random(seed) & 32'h0000_00fc) + 32'h100 * k;
            bus(1'b1, RD_ADDR_OFS, base);
            if (k == 2)
                bus(1'b1, CTRL_OFS, 32'h0000_0003);
            rd_seq(base, 12 - 4 * k);
        end
        bus(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0000_0001)
        base = 32'h340;
        bus(1'b1, RD_ADDR_OFS, base);
        bus(1'b0, DATA_SG_OFS, 32'h0);
        `CHK(rd, word_at(base))
        done("read bursts");
        base = 32'h200 + ($random(seed) & 32'h3c);
        bus(1'b1, WR_ADDR_OFS, base);
        wr_seq(10);
        bus(1'b1, WR_ADDR_OFS, 32'h300);
        repeat (2) @(posedge ref_clk);
        mem_chk(base, 10);
        wr_seq(3);
        repeat (80) @(posedge ref_clk);
        mem_chk(32'h300, 3);
        done("write bursts");
        stall <= 1'b1;
        bus(1'b1, WR_ADDR_OFS, 32'h340);
        wr_seq(8);
        wd[8] = 32'h1234_5678;
        fork
            bus(1'b1, DATA_AI_OFS, wd[8]);
            begin
                repeat (20) @(posedge ref_clk);
                `CHK(host_ready_n, 1'b1)
                stall <= 1'b0;
            end
        join
        bus(1'b1, WR_ADDR_OFS, 32'h380);
        repeat (2) @(posedge ref_clk);
        mem_chk(32'h340, 9);
        done("full hold-off");
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b1, SH_ADDR_OFS, 32'h3c0);
        wr_seq(2);
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b0, DATA_AI_OFS, 32'h0);
            `CHK(rd, wd[i])
        end
        bus(1'b1, WR_ADDR_OFS, 32'h3e0);
        wd[0] = $random(seed);
        bus(1'b1, DATA_SG_OFS, wd[0]);
        bus(1'b1, WR_ADDR_OFS, 32'h3e4);
        mem_chk(32'h3e0, 1);
        done("coupled flush and single write");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
